// ==== design/irq_ctrl_pkg.sv ====
package irq_ctrl_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets on the Avalon-MM slave
   // ---------------------------------------------------------------
   localparam logic [5:0] reset_control_register_off   = 6'h00;
   localparam logic [5:0] main_irq_control_off         = 6'h04;
   localparam logic [5:0] peripheral_flag_reg_1_off    = 6'h08;
   localparam logic [5:0] peripheral_enable_reg_1_off  = 6'h0c;
   localparam logic [5:0] peripheral_priority_reg_1_off = 6'h10;
   localparam logic [5:0] peripheral_irq_enable_2_off  = 6'h14;
   localparam logic [5:0] peripheral_flag_reg_2_off    = 6'h18;
   localparam logic [5:0] peripheral_priority_reg_2_off = 6'h1c;
   localparam logic [5:0] irq_event_status_off         = 6'h20;
   localparam logic [5:0] irq_event_mask_off           = 6'h24;
   localparam logic [5:0] service_state_off            = 6'h28;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int priority_mode_enable_bit     = 7;
   localparam int high_level_global_enable_bit = 7;
   localparam int low_level_global_enable_bit  = 6;
   localparam int single_global_enable_bit     = 7;
   localparam int peripheral_group_enable_bit  = 6;
   localparam int osc_fail_irq_enable_bit      = 7;
   localparam int bus_collision_irq_enable_bit = 3;
   localparam int voltage_detect_irq_enable_bit = 2;
   localparam int timer_three_overflow_enable_bit = 1;
   localparam int timer_three_gate_enable_bit  = 0;
   localparam int ev_accept_high_bit           = 0;
   localparam int ev_accept_low_bit            = 1;
   localparam int ev_return_bit                = 2;

   // Writable bits of the second peripheral enable, main control, reset control and event mask registers
   localparam logic [7:0] peripheral_irq_enable_2_wmask = 8'h8f;
   localparam logic [7:0] main_irq_control_wmask        = 8'hc0;
   localparam logic [7:0] reset_control_register_wmask  = 8'h80;
   localparam logic [2:0] irq_event_wmask               = 3'h7;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] reg8_reset_value   = 8'h00;
   localparam logic [2:0] irq_event_reset    = 3'h0;

   // ---------------------------------------------------------------
   // Vectors and timing
   // ---------------------------------------------------------------
   localparam logic [15:0] high_vector_addr = 16'h0008;
   localparam logic [15:0] low_vector_addr  = 16'h0018;
   localparam int mclk_period_ns       = 40;
   localparam int clocks_per_tcy       = 4;
   localparam int entry_latency_tcy    = 3;

   typedef enum logic [1:0] {
      svc_idle = 2'b00,
      svc_low  = 2'b01,
      svc_high = 2'b10,
      svc_both = 2'b11
   } svc_state_t;

   // Vectoring command to the core sequencer
   typedef struct packed {
      logic        push_return;
      logic        load_pc;
      logic [15:0] vector;
   } core_entry_t;

endpackage

// ==== design/irq_entry_pipe.sv ====
`timescale 1ns/100ps
module irq_entry_pipe
   import irq_ctrl_pkg::*;
#(
   parameter int STAGES = entry_latency_tcy
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        tcy_en,
   input  wire logic        start,
   input  wire logic [15:0] vector_in,
   output logic             busy,
   output core_entry_t      entry
);

   // ------------------------------------------------------------
   // Holds an accepted request for STAGES instruction cycles
   // ------------------------------------------------------------
   logic [3:0]  remain;
   logic [3:0]  next_remain;
   logic [15:0] vector_q;
   logic [15:0] next_vector_q;
   logic        fire;
   logic        next_fire;

   always_comb begin
      next_remain   = remain;
      next_vector_q = vector_q;
      next_fire     = 1'b0;
      if (start) begin
         next_remain   = 4'(STAGES);
         next_vector_q = vector_in;
      end else if (tcy_en && remain != 4'h0) begin
         next_remain = remain - 4'h1;
         if (remain == 4'h1) begin
            next_fire = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         remain   <= 4'h0;
         vector_q <= 16'h0000;
         fire     <= 1'b0;
      end else begin
         remain   <= next_remain;
         vector_q <= next_vector_q;
         fire     <= next_fire;
      end
   end

   assign busy              = (remain != 4'h0) || fire;
   assign entry.push_return = fire;
   assign entry.load_pc     = fire;
   assign entry.vector      = vector_q;

endmodule

// ==== design/tcy_enable_gen.sv ====
`timescale 1ns/100ps
module tcy_enable_gen
   import irq_ctrl_pkg::*;
#(
   parameter int DIVIDE = clocks_per_tcy
) (
   input  wire logic mclk,
   input  wire logic rst,
   output logic      tcy_en
);

   // ------------------------------------------------------------
   // Instruction cycle enable, one mclk pulse every DIVIDE clocks
   // ------------------------------------------------------------
   logic [7:0] count;
   logic [7:0] next_count;

   always_comb begin
      if (count == 8'(DIVIDE - 1)) begin
         next_count = 8'h00;
      end else begin
         next_count = count + 8'h01;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         count <= 8'h00;
      end else begin
         count <= next_count;
      end
   end

   assign tcy_en = (count == 8'(DIVIDE - 1));

endmodule

// ==== design/two_level_interrupt_controller.sv ====
// Behaviour
// (RULE1) High requests vector to 0008h, low requests vector to 0018h.
// (RULE2) A high request may pre-empt a low service routine in progress.
// (RULE3) Each source has a flag, an enable and a priority select bit.
// (RULE4) Two-level priority works only while priority mode enable is set.
// (RULE5) In priority mode the high global enable gates priority-set sources.
// (RULE6) In priority mode the low global enable gates priority-clear sources.
// (RULE7) Flag, enable and matching global enable set vector to chosen address.
// (RULE8) Priority mode enable clear by default gives compatibility mode, priority ignored.
// (RULE9) Compatibility: bit 6 gates peripherals, bit 7 gates all sources.
// (RULE10) Compatibility mode sends every accepted request to 0008h.
// (RULE11) Acceptance clears the governing global enable for that level.
// (RULE12) No low request is accepted while high service is in progress.
// (RULE13) Acceptance pushes return address and loads PC with the vector.
// (RULE14) Software clears pending flags before re-enabling interrupts.
// (RULE15) Return from interrupt leaves service and sets the cleared enable.
// (RULE16) External event to vectoring takes three to four instruction cycles.
// (RULE17) Flags set on every event regardless of enables.
// (RULE18) Second enable register: bit7, three zero bits, then bits 3 to 0.
// (RULE19) Pending is flag AND enable, then gated by group and global enables.
`timescale 1ns/100ps
module two_level_interrupt_controller
   import irq_ctrl_pkg::*;
#(
   parameter int         NUM_SRC       = 8,
   parameter logic [7:0] PERIPH_MASK_1 = 8'hf0,
   parameter int         TCY_DIVIDE    = clocks_per_tcy,
   parameter int         ENTRY_STAGES  = entry_latency_tcy
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic [5:0]   address,
   input  wire logic         read,
   input  wire logic         write,
   input  wire logic [31:0]  writedata,
   input  wire logic [3:0]   byteenable,
   output logic [31:0]       readdata,
   output logic              waitrequest,
   input  wire logic [7:0]   src_event_1,
   input  wire logic [7:0]   src_event_2,
   input  wire logic         return_from_irq_instr,
   output core_entry_t       core_entry,
   output logic              irq
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] reset_control_register;
   logic [7:0] main_irq_control;
   logic [7:0] peripheral_flag_reg_1;
   logic [7:0] peripheral_enable_reg_1;
   logic [7:0] peripheral_priority_reg_1;
   logic [7:0] peripheral_irq_enable_2;
   logic [7:0] peripheral_flag_reg_2;
   logic [7:0] peripheral_priority_reg_2;
   logic [2:0] irq_event_status;
   logic [2:0] irq_event_mask;
   svc_state_t svc;

   logic [7:0] next_reset_control_register;
   logic [7:0] next_main_irq_control;
   logic [7:0] next_peripheral_flag_reg_1;
   logic [7:0] next_peripheral_enable_reg_1;
   logic [7:0] next_peripheral_priority_reg_1;
   logic [7:0] next_peripheral_irq_enable_2;
   logic [7:0] next_peripheral_flag_reg_2;
   logic [7:0] next_peripheral_priority_reg_2;
   logic [2:0] next_irq_event_status;
   logic [2:0] next_irq_event_mask;
   svc_state_t next_svc;

   logic        ack;
   logic        next_ack;
   logic [31:0] rdata_q;
   logic [31:0] next_rdata_q;

   // ---------------------------------------------------------------
   // Bus slave: one wait state, write commits on the acknowledged edge
   // ---------------------------------------------------------------
   logic wr_go;
   logic rd_go;
   logic lane0;
   logic [7:0] wbyte;

   assign waitrequest = (read || write) && !ack;
   assign wr_go       = write && ack;
   assign rd_go       = read && ack;
   assign lane0       = byteenable[0];
   assign wbyte       = writedata[7:0];
   assign readdata    = rdata_q;

   always_comb begin
      next_ack     = (read || write) && !ack;
      next_rdata_q = rdata_q;
      if (read && !ack) begin
         if (address == reset_control_register_off) begin
            next_rdata_q = {24'h000000, reset_control_register};
         end else if (address == main_irq_control_off) begin
            next_rdata_q = {24'h000000, main_irq_control};
         end else if (address == peripheral_flag_reg_1_off) begin
            next_rdata_q = {24'h000000, peripheral_flag_reg_1};
         end else if (address == peripheral_enable_reg_1_off) begin
            next_rdata_q = {24'h000000, peripheral_enable_reg_1};
         end else if (address == peripheral_priority_reg_1_off) begin
            next_rdata_q = {24'h000000, peripheral_priority_reg_1};
         end else if (address == peripheral_irq_enable_2_off) begin
            next_rdata_q = {24'h000000, peripheral_irq_enable_2 & peripheral_irq_enable_2_wmask}; // RULE18
         end else if (address == peripheral_flag_reg_2_off) begin
            next_rdata_q = {24'h000000, peripheral_flag_reg_2};
         end else if (address == peripheral_priority_reg_2_off) begin
            next_rdata_q = {24'h000000, peripheral_priority_reg_2};
         end else if (address == irq_event_status_off) begin
            next_rdata_q = {29'h00000000, irq_event_status};
         end else if (address == irq_event_mask_off) begin
            next_rdata_q = {29'h00000000, irq_event_mask};
         end else if (address == service_state_off) begin
            next_rdata_q = {30'h00000000, svc};
         end else begin
            next_rdata_q = 32'h00000000;
         end
      end
   end

   // ---------------------------------------------------------------
   // Request qualification
   // ---------------------------------------------------------------
   logic        tcy_en;
   logic        pipe_busy;
   logic [15:0] pend_1;
   logic [15:0] pend_all;
   logic [15:0] prio_all;
   logic [15:0] periph_all;
   logic        prio_mode;
   logic        gate_hi;
   logic        gate_lo;
   logic        high_req;
   logic        low_req;
   logic        compat_req;
   logic        accept_high;
   logic        accept_low;
   logic        accept_any;
   logic [15:0] accept_vector;
   logic        in_high;

   assign pend_1     = {8'h00, peripheral_flag_reg_1 & peripheral_enable_reg_1}; // RULE19
   assign pend_all   = {peripheral_flag_reg_2 & peripheral_irq_enable_2 & peripheral_irq_enable_2_wmask,
                        pend_1[7:0]}; // RULE19 RULE3
   assign prio_all   = {peripheral_priority_reg_2 & peripheral_irq_enable_2_wmask,
                        peripheral_priority_reg_1}; // RULE3
   assign periph_all = {8'hff, PERIPH_MASK_1};
   assign prio_mode  = reset_control_register[priority_mode_enable_bit]; // RULE4 RULE8
   assign gate_hi    = main_irq_control[high_level_global_enable_bit];
   assign gate_lo    = main_irq_control[low_level_global_enable_bit];
   assign in_high    = (svc == svc_high) || (svc == svc_both);

   // Priority bits take effect only in priority mode
   assign high_req   = prio_mode && gate_hi && |(pend_all & prio_all); // RULE5 RULE7
   assign low_req    = prio_mode && gate_lo && !in_high && |(pend_all & ~prio_all); // RULE6 RULE7 RULE12
   assign compat_req = !prio_mode && main_irq_control[single_global_enable_bit]
                       && |(pend_all & (~periph_all | {16{main_irq_control[peripheral_group_enable_bit]}})); // RULE9 RULE8

   // Decisions are taken on instruction cycle boundaries, one entry at a time
   assign accept_high = tcy_en && !pipe_busy && (high_req || compat_req); // RULE2
   assign accept_low  = tcy_en && !pipe_busy && !high_req && !compat_req && low_req;
   assign accept_any  = accept_high || accept_low;
   assign accept_vector = (accept_low && prio_mode) ? low_vector_addr : high_vector_addr; // RULE1 RULE10

   // ---------------------------------------------------------------
   // Register and service state update
   // ---------------------------------------------------------------
   logic ret_go;

   assign ret_go = return_from_irq_instr && (svc != svc_idle);

   always_comb begin
      next_reset_control_register    = reset_control_register;
      next_main_irq_control          = main_irq_control;
      next_peripheral_flag_reg_1     = peripheral_flag_reg_1;
      next_peripheral_enable_reg_1   = peripheral_enable_reg_1;
      next_peripheral_priority_reg_1 = peripheral_priority_reg_1;
      next_peripheral_irq_enable_2   = peripheral_irq_enable_2;
      next_peripheral_flag_reg_2     = peripheral_flag_reg_2;
      next_peripheral_priority_reg_2 = peripheral_priority_reg_2;
      next_irq_event_mask            = irq_event_mask;
      next_irq_event_status          = irq_event_status;
      next_svc                       = svc;

      if (wr_go && lane0) begin
         if (address == reset_control_register_off) begin
            next_reset_control_register = wbyte & reset_control_register_wmask;
         end else if (address == main_irq_control_off) begin
            next_main_irq_control = wbyte & main_irq_control_wmask;
         end else if (address == peripheral_flag_reg_1_off) begin
            next_peripheral_flag_reg_1 = wbyte;
         end else if (address == peripheral_enable_reg_1_off) begin
            next_peripheral_enable_reg_1 = wbyte;
         end else if (address == peripheral_priority_reg_1_off) begin
            next_peripheral_priority_reg_1 = wbyte;
         end else if (address == peripheral_irq_enable_2_off) begin
            next_peripheral_irq_enable_2 = wbyte & peripheral_irq_enable_2_wmask; // RULE18
         end else if (address == peripheral_flag_reg_2_off) begin
            next_peripheral_flag_reg_2 = wbyte & peripheral_irq_enable_2_wmask;
         end else if (address == peripheral_priority_reg_2_off) begin
            next_peripheral_priority_reg_2 = wbyte & peripheral_irq_enable_2_wmask;
         end else if (address == irq_event_mask_off) begin
            next_irq_event_mask = wbyte[2:0] & irq_event_wmask;
         end
      end

      // Events set flags after any software write, so a set wins
      next_peripheral_flag_reg_1 = next_peripheral_flag_reg_1 | src_event_1; // RULE17
      next_peripheral_flag_reg_2 = next_peripheral_flag_reg_2 | (src_event_2 & peripheral_irq_enable_2_wmask); // RULE17

      // Return restores the enable of the level being left
      if (ret_go) begin
         if (!prio_mode) begin
            next_main_irq_control[single_global_enable_bit] = 1'b1; // RULE15
            next_svc = svc_idle;
         end else if (in_high) begin
            next_main_irq_control[high_level_global_enable_bit] = 1'b1; // RULE15
            next_svc = (svc == svc_both) ? svc_low : svc_idle;
         end else begin
            next_main_irq_control[low_level_global_enable_bit] = 1'b1; // RULE15
            next_svc = svc_idle;
         end
      end

      // Entry clears the enable that governed the accepted request
      if (accept_high) begin
         if (prio_mode) begin
            next_main_irq_control[high_level_global_enable_bit] = 1'b0; // RULE11
         end else begin
            next_main_irq_control[single_global_enable_bit] = 1'b0; // RULE11
         end
         next_svc = (next_svc == svc_low) ? svc_both : svc_high; // RULE2
      end else if (accept_low) begin
         next_main_irq_control[low_level_global_enable_bit] = 1'b0; // RULE11
         next_svc = svc_low;
      end

      // Sticky status: read clears, a new event in that cycle wins
      if (rd_go && address == irq_event_status_off) begin
         next_irq_event_status = irq_event_reset;
      end
      next_irq_event_status[ev_accept_high_bit] = next_irq_event_status[ev_accept_high_bit] | accept_high;
      next_irq_event_status[ev_accept_low_bit]  = next_irq_event_status[ev_accept_low_bit] | accept_low;
      next_irq_event_status[ev_return_bit]      = next_irq_event_status[ev_return_bit] | ret_go;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reset_control_register    <= reg8_reset_value;
         main_irq_control          <= reg8_reset_value;
         peripheral_flag_reg_1     <= reg8_reset_value;
         peripheral_enable_reg_1   <= reg8_reset_value;
         peripheral_priority_reg_1 <= reg8_reset_value;
         peripheral_irq_enable_2   <= reg8_reset_value;
         peripheral_flag_reg_2     <= reg8_reset_value;
         peripheral_priority_reg_2 <= reg8_reset_value;
         irq_event_status          <= irq_event_reset;
         irq_event_mask            <= irq_event_reset;
         svc                       <= svc_idle;
         ack                       <= 1'b0;
         rdata_q                   <= 32'h00000000;
      end else begin
         reset_control_register    <= next_reset_control_register;
         main_irq_control          <= next_main_irq_control;
         peripheral_flag_reg_1     <= next_peripheral_flag_reg_1;
         peripheral_enable_reg_1   <= next_peripheral_enable_reg_1;
         peripheral_priority_reg_1 <= next_peripheral_priority_reg_1;
         peripheral_irq_enable_2   <= next_peripheral_irq_enable_2;
         peripheral_flag_reg_2     <= next_peripheral_flag_reg_2;
         peripheral_priority_reg_2 <= next_peripheral_priority_reg_2;
         irq_event_status          <= next_irq_event_status;
         irq_event_mask            <= next_irq_event_mask;
         svc                       <= next_svc;
         ack                       <= next_ack;
         rdata_q                   <= next_rdata_q;
      end
   end

   assign irq = |(irq_event_status & irq_event_mask);

   // ---------------------------------------------------------------
   // Instruction clock and entry sequencing
   // ---------------------------------------------------------------
   tcy_enable_gen #(
      .DIVIDE (TCY_DIVIDE)
   ) u_tcy (
      .mclk   (mclk),
      .rst    (rst),
      .tcy_en (tcy_en)
   );

   // Fixed pipeline makes latency independent of instruction length
   irq_entry_pipe #(
      .STAGES    (ENTRY_STAGES)
   ) u_entry (
      .mclk      (mclk),
      .rst       (rst),
      .tcy_en    (tcy_en),
      .start     (accept_any), // RULE16
      .vector_in (accept_vector),
      .busy      (pipe_busy),
      .entry     (core_entry) // RULE13
   );

endmodule

// ==== testbench/core_model.sv ====
`timescale 1ns/100ps
module core_model
   import irq_ctrl_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire core_entry_t core_entry,
   input wire logic        do_return,
   output logic            return_from_irq_instr,
   output logic [3:0]      depth
);
   // ------------------------------------------------------------
   // Return stack depth and return pulse
   // ------------------------------------------------------------
   logic       next_ret;
   logic [3:0] next_depth;
   always_comb begin
      next_ret = do_return && depth != 4'h0;
      next_depth = depth + {3'h0, core_entry.push_return} - {3'h0, next_ret};
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         return_from_irq_instr <= 1'b0;
         depth <= 4'h0;
      end else begin
         return_from_irq_instr <= next_ret;
         depth <= next_depth;
      end
   end
endmodule

// ==== testbench/irq_ctrl_asserts.sv ====
`timescale 1ns/100ps
module irq_ctrl_asserts
   import irq_ctrl_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [5:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire core_entry_t core_entry
);
   // ------------------------------------------------------------
   // Bus answer and core entry checks
   // ------------------------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence req_s; (read || write) && waitrequest; endsequence
   sequence ans_s; (read || write) && !waitrequest; endsequence
   sequence entry_s; core_entry.load_pc && core_entry.push_return; endsequence
   chk_wait_one: assert property (req_s |=> ans_s) else $error("wait state not one cycle");
   chk_wait_idle: assert property (!(read || write) |-> !waitrequest) else $error("wait without request");
   chk_read_upper: assert property (ans_s and read |-> readdata[31:8] == 24'h0) else $error("upper bits set");
   chk_enable_two_gap: assert property (ans_s and read && address == 6'h14 |-> readdata[6:4] == 3'h0)
      else $error("unimplemented bits set");
   chk_entry_pair: assert property (core_entry.load_pc == core_entry.push_return) else $error("entry split");
   chk_entry_gap: assert property (entry_s |=> (!core_entry.load_pc) [*8]) else $error("entries too close");
   chk_vector_legal: assert property (entry_s |-> core_entry.vector inside {16'h0008, 16'h0018})
      else $error("bad vector");
   chk_vector_hold: assert property ($changed(core_entry.vector) |-> (!core_entry.load_pc) [*8])
      else $error("vector moved");
endmodule

// ==== testbench/two_level_interrupt_controller_tb.sv ====
`timescale 1ns/100ps
module two_level_interrupt_controller_tb
   import irq_ctrl_pkg::*;
;
   logic        mclk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, do_return = 1'b0;
   logic [5:0]  address = 6'h0;
   logic [31:0] writedata = 32'h0, readdata;
   logic [7:0]  src_event_1 = 8'h0, src_event_2 = 8'h0;
   logic [3:0]  byteenable = 4'h1, depth;
   logic        waitrequest, return_from_irq_instr, irq;
   core_entry_t core_entry;
   int          num_errors = 0, num_checks = 0;
   always #20 mclk = ~mclk;
   two_level_interrupt_controller i_dut (.mclk, .rst, .address, .read, .write, .writedata, .byteenable,
      .readdata, .waitrequest, .src_event_1, .src_event_2, .return_from_irq_instr, .core_entry, .irq);
   core_model i_core (.mclk, .rst, .core_entry, .do_return, .return_from_irq_instr, .depth);
   // ------------------------------------------------------------
   // Shared tasks and scenarios
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test(input int extra);
      num_errors += extra;
      if (num_errors == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic acc(input logic [5:0] a, input logic w, input logic [7:0] d);
      int n;
      @(posedge mclk);
      address <= a;
      write <= w;
      read <= !w;
      writedata <= {24'h0, d};
      for (n = 0; n < 9; n++) begin
         @(posedge mclk);
         if (waitrequest === 1'b0) break;
      end
      read <= 1'b0;
      write <= 1'b0;
      if (n == 9) finish_test(1);
      if (!w) chk({8'h0, readdata[7:0]}, {8'h0, d});
   endtask
   task automatic pulse(input logic [7:0] ev, input logic r);
      @(posedge mclk);
      src_event_1 <= ev;
      do_return <= r;
      @(posedge mclk);
      src_event_1 <= 8'h0;
      do_return <= 1'b0;
   endtask
   // A zero vector means no entry may happen
   task automatic entry(input logic [15:0] exp);
      int n;
      for (n = 0; n < 30; n++) begin
         @(negedge mclk);
         if (core_entry.load_pc === 1'b1) break;
      end
      if (exp == 16'h0) chk(16'(n), 16'd30);
      else begin
         chk(core_entry.vector, exp);
         chk(16'(n >= 12 && n <= 19), 16'h1);
         if (n == 30) finish_test(1);
      end
   endtask
   task automatic irq_is(input logic e);
      @(negedge mclk);
      chk({15'h0, irq}, {15'h0, e});
   endtask
   task automatic s_regs;
      acc(6'h00, 1'b0, 8'h00);
      acc(6'h14, 1'b0, 8'h00);
      acc(6'h14, 1'b1, 8'hff);
      acc(6'h14, 1'b0, 8'h8f);
      byteenable <= 4'h0;
      acc(6'h14, 1'b1, 8'h00);
      byteenable <= 4'h1;
      acc(6'h14, 1'b0, 8'h8f);
      src_event_2 <= 8'hff;
      acc(6'h18, 1'b0, 8'h8f);
      src_event_2 <= 8'h00;
      acc(6'h18, 1'b1, 8'h00);
      acc(6'h18, 1'b0, 8'h00);
      acc(6'h3c, 1'b0, 8'h00);
   endtask
   task automatic s_compat;
      acc(6'h0c, 1'b1, 8'h11);
      acc(6'h04, 1'b1, 8'h80);
      pulse(8'h30, 1'b0);
      entry(16'h0);
      acc(6'h08, 1'b0, 8'h30);
      acc(6'h08, 1'b1, 8'h00);
      pulse(8'h01, 1'b0);
      entry(high_vector_addr);
      acc(6'h04, 1'b0, 8'h00);
      acc(6'h08, 1'b1, 8'h00);
      pulse(8'h00, 1'b1);
      acc(6'h04, 1'b0, 8'h80);
      acc(6'h04, 1'b1, 8'hc0);
      pulse(8'h10, 1'b0);
      entry(high_vector_addr);
      acc(6'h08, 1'b1, 8'h00);
      pulse(8'h00, 1'b1);
   endtask
   task automatic s_prio;
      acc(6'h00, 1'b1, 8'h80);
      acc(6'h10, 1'b1, 8'h01);
      acc(6'h0c, 1'b1, 8'h03);
      acc(6'h24, 1'b1, 8'h03);
      acc(6'h04, 1'b1, 8'hc0);
      pulse(8'h02, 1'b0);
      entry(low_vector_addr);
      acc(6'h04, 1'b0, 8'h80);
      irq_is(1'b1);
      acc(6'h20, 1'b0, 8'h07);
      irq_is(1'b0);
      pulse(8'h01, 1'b0);
      entry(high_vector_addr);
      acc(6'h28, 1'b0, 8'h03);
      chk({12'h0, depth}, 16'h2);
      acc(6'h24, 1'b1, 8'h02);
      irq_is(1'b0);
      acc(6'h08, 1'b1, 8'h00);
      pulse(8'h00, 1'b1);
      acc(6'h04, 1'b0, 8'h80);
      pulse(8'h00, 1'b1);
      acc(6'h04, 1'b0, 8'hc0);
      acc(6'h20, 1'b0, 8'h05);
      pulse(8'h01, 1'b0);
      entry(high_vector_addr);
      pulse(8'h02, 1'b0);
      entry(16'h0);
      acc(6'h08, 1'b1, 8'h02);
      pulse(8'h00, 1'b1);
      entry(low_vector_addr);
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      s_regs;
      s_compat;
      s_prio;
      finish_test(0);
   end
endmodule
bind two_level_interrupt_controller irq_ctrl_asserts u_chk (.mclk, .rst, .address, .read, .write, .readdata,
   .waitrequest, .core_entry);
